// ===== hdl/psbp_pkg.sv
// constants for the parallel slave byte port
// assumes a single sys_clk domain split into four phase slots
package psbp_pkg;

  localparam int unsigned PSBP_DATA_W    = 8;
  localparam int unsigned PSBP_PHASE_W   = 2;
  localparam int unsigned PSBP_SYNC_LEN  = 2;

  // phase slots of the internal instruction cycle
  localparam logic [PSBP_PHASE_W-1:0] PSBP_PHASE_TWO  = 2'h1;
  localparam logic [PSBP_PHASE_W-1:0] PSBP_PHASE_FOUR = 2'h3;
  localparam logic [PSBP_PHASE_W-1:0] PSBP_PHASE_RST  = 2'h0;
  localparam logic [PSBP_PHASE_W-1:0] PSBP_PHASE_STEP = 2'h1;

  // reset values
  localparam logic [PSBP_DATA_W-1:0] PSBP_LATCH_RST = 8'h00;
  localparam logic                   PSBP_FLAG_RST  = 1'b0;
  localparam logic                   PSBP_STROBE_IDLE = 1'b1;

  // completion report sequencer, one-hot
  typedef enum logic [2:0] {
    PSBP_DONE_IDLE  = 3'b001,
    PSBP_DONE_WAIT2 = 3'b010,
    PSBP_DONE_WAIT4 = 3'b100
  } psbp_done_t;

endpackage

// ===== hdl/psbp_port.sv
// parallel slave byte port: external 8-bit master reads/writes a latch pair
// assumes data pins and firmware strobes are synchronous to sys_clk;
// firmware strobes are one-cycle pulses, strobes from the master are async
`timescale 1ns/1ps
`default_nettype none

module psbp_port
  import psbp_pkg::*;
(
  // clock, reset, enable
  input  wire logic                              sys_clk,
  input  wire logic                              rstn,
  input  wire logic                              clkEn,
  // firmware configuration
  input  wire logic                              slaveModeEnable,
  input  wire logic [psbp_pkg::PSBP_DATA_W-1:0]  dataPinDirection,
  input  wire logic                              portIrqEnable,
  // firmware data access
  input  wire logic                              fwDataWrite,
  input  wire logic [psbp_pkg::PSBP_DATA_W-1:0]  fwWriteData,
  input  wire logic                              fwDataRead,
  output logic      [psbp_pkg::PSBP_DATA_W-1:0]  fwReadData,
  // firmware flag clears
  input  wire logic                              fwOverflowClear,
  input  wire logic                              fwIrqClear,
  // status
  output logic                                   inputFullFlag,
  output logic                                   outputFullFlag,
  output logic                                   inputOverflowFlag,
  output logic                                   portIrqFlag,
  output logic                                   portIrqRequest,
  // external control pins
  input  wire logic                              readStrobeN,
  input  wire logic                              writeStrobeN,
  input  wire logic                              chipSelectN,
  // external data pins
  input  wire logic [psbp_pkg::PSBP_DATA_W-1:0]  dataPinIn,
  output logic      [psbp_pkg::PSBP_DATA_W-1:0]  dataPinOut,
  output logic      [psbp_pkg::PSBP_DATA_W-1:0]  dataPinOeN
);

  import psbp_pkg::*;

  // strobe synchronisers
  logic [PSBP_SYNC_LEN-1:0] rdSync_reg;
  logic [PSBP_SYNC_LEN-1:0] wrSync_reg;
  logic [PSBP_SYNC_LEN-1:0] csSync_reg;
  logic [PSBP_SYNC_LEN-1:0] rdSync_next;
  logic [PSBP_SYNC_LEN-1:0] wrSync_next;
  logic [PSBP_SYNC_LEN-1:0] csSync_next;
  logic                     writeActive;
  logic                     readActive;
  logic                     writeWasActive_reg;
  logic                     readWasActive_reg;
  logic                     writeEnd;
  logic                     readStart;
  logic                     readEnd;

  // phase slots
  logic [PSBP_PHASE_W-1:0]  phase_reg;
  logic [PSBP_PHASE_W-1:0]  phase_next;
  logic                     atPhaseTwo;
  logic                     atPhaseFour;

  // completion sequencers
  psbp_done_t               wrDone_reg;
  psbp_done_t               wrDone_next;
  psbp_done_t               rdDone_reg;
  psbp_done_t               rdDone_next;
  logic                     wrReport;
  logic                     rdReport;

  // latches and flags
  logic [PSBP_DATA_W-1:0]   inLatch_reg;
  logic [PSBP_DATA_W-1:0]   inLatch_next;
  logic [PSBP_DATA_W-1:0]   outLatch_reg;
  logic [PSBP_DATA_W-1:0]   outLatch_next;
  logic [PSBP_DATA_W-1:0]   lastWriteData_reg;
  logic [PSBP_DATA_W-1:0]   lastWriteData_next;
  logic [PSBP_DATA_W-1:0]   readData_reg;
  logic [PSBP_DATA_W-1:0]   readData_next;
  logic                     ibf_reg;
  logic                     ibf_next;
  logic                     obf_reg;
  logic                     obf_next;
  logic                     input_overflow_flag_reg;
  logic                     input_overflow_flag_next;
  logic                     ovfReadSeen_reg;
  logic                     ovfReadSeen_next;
  logic                     irq_reg;
  logic                     irq_next;

  // strobe synchroniser: stage 0 feeds only stage 1
  always_comb
  begin
    rdSync_next = {rdSync_reg[0], readStrobeN};
    wrSync_next = {wrSync_reg[0], writeStrobeN};
    csSync_next = {csSync_reg[0], chipSelectN};
  end

  // detected strobe levels, gated by slave mode
  assign writeActive = slaveModeEnable && !csSync_reg[1] && !wrSync_reg[1];
  assign readActive  = slaveModeEnable && !csSync_reg[1] && !rdSync_reg[1];
  // level triggered ends: either line high closes the cycle
  assign writeEnd    = writeWasActive_reg && !writeActive;
  assign readStart   = !readWasActive_reg && readActive;
  assign readEnd     = readWasActive_reg && !readActive;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rdSync_reg         <= {PSBP_SYNC_LEN{PSBP_STROBE_IDLE}};
      wrSync_reg         <= {PSBP_SYNC_LEN{PSBP_STROBE_IDLE}};
      csSync_reg         <= {PSBP_SYNC_LEN{PSBP_STROBE_IDLE}};
      writeWasActive_reg <= PSBP_FLAG_RST;
      readWasActive_reg  <= PSBP_FLAG_RST;
    end
    else if (clkEn)
    begin
      rdSync_reg         <= rdSync_next;
      wrSync_reg         <= wrSync_next;
      csSync_reg         <= csSync_next;
      writeWasActive_reg <= writeActive;
      readWasActive_reg  <= readActive;
    end
  end

  // four phase slots per instruction cycle
  always_comb
  begin
    phase_next = phase_reg + PSBP_PHASE_STEP;
  end

  assign atPhaseTwo  = (phase_reg == PSBP_PHASE_TWO);
  assign atPhaseFour = (phase_reg == PSBP_PHASE_FOUR);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      phase_reg <= PSBP_PHASE_RST;
    else if (clkEn)
      phase_reg <= phase_next;
  end

  // completion report: wait for the next phase two, then report on phase four
  function automatic psbp_done_t psbp_done_step(
    input psbp_done_t cur,
    input logic       start,
    input logic       p2,
    input logic       p4
  );
    psbp_done_t nxt;
    nxt = cur;
    unique case (cur)
      PSBP_DONE_IDLE:
        if (start)
          nxt = PSBP_DONE_WAIT2;
      PSBP_DONE_WAIT2:
        if (p2)
          nxt = PSBP_DONE_WAIT4;
      PSBP_DONE_WAIT4:
        if (p4)
          nxt = PSBP_DONE_IDLE;
      default:
        nxt = PSBP_DONE_IDLE;
    endcase
    return nxt;
  endfunction

  always_comb
  begin
    wrDone_next = psbp_done_step(wrDone_reg, writeEnd, atPhaseTwo, atPhaseFour);
    rdDone_next = psbp_done_step(rdDone_reg, readEnd, atPhaseTwo, atPhaseFour);
  end

  assign wrReport = (wrDone_reg == PSBP_DONE_WAIT4) && atPhaseFour;
  assign rdReport = (rdDone_reg == PSBP_DONE_WAIT4) && atPhaseFour;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wrDone_reg <= PSBP_DONE_IDLE;
      rdDone_reg <= PSBP_DONE_IDLE;
    end
    else if (clkEn)
    begin
      wrDone_reg <= wrDone_next;
      rdDone_reg <= rdDone_next;
    end
  end

  // latches and status flags; hardware sets win over firmware clears
  always_comb
  begin
    inLatch_next       = inLatch_reg;
    outLatch_next      = outLatch_reg;
    lastWriteData_next = lastWriteData_reg;
    ibf_next           = ibf_reg;
    obf_next           = obf_reg;
    input_overflow_flag_next          = input_overflow_flag_reg;
    ovfReadSeen_next   = ovfReadSeen_reg;
    irq_next           = irq_reg;

    // pins are sampled during the write so the byte survives synchroniser lag
    if (writeActive)
      lastWriteData_next = dataPinIn;
    if (writeEnd)
      inLatch_next = lastWriteData_next;

    // firmware write always reaches the latch, even mid-read
    if (fwDataWrite)
      outLatch_next = fwWriteData;

    // input full
    if (fwDataRead)
      ibf_next = 1'b0;
    if (wrReport)
      ibf_next = 1'b1;

    // output full: cleared by read start and held clear during a read
    if (fwDataWrite && !readActive)
      obf_next = 1'b1;
    if (readStart || readActive)
      obf_next = 1'b0;

    // overflow needs both a data read and a clear write; never self-clears
    if (fwDataRead && input_overflow_flag_reg)
      ovfReadSeen_next = 1'b1;
    if (fwOverflowClear && (ovfReadSeen_reg || (fwDataRead && input_overflow_flag_reg)))
    begin
      input_overflow_flag_next        = 1'b0;
      ovfReadSeen_next = 1'b0;
    end
    if (wrReport && ibf_reg)
    begin
      input_overflow_flag_next        = 1'b1;
      ovfReadSeen_next = 1'b0;
    end

    // irq flag
    if (fwIrqClear)
      irq_next = 1'b0;
    if (wrReport || rdReport)
      irq_next = 1'b1;

    // leaving slave mode holds both full flags clear, overflow untouched
    if (!slaveModeEnable)
    begin
      ibf_next = 1'b0;
      obf_next = 1'b0;
    end
  end

  // firmware read: live pins during a write or outside slave mode, else latch
  always_comb
  begin
    if (!slaveModeEnable || writeActive)
      readData_next = dataPinIn;
    else
      readData_next = inLatch_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      inLatch_reg       <= PSBP_LATCH_RST;
      outLatch_reg      <= PSBP_LATCH_RST;
      lastWriteData_reg <= PSBP_LATCH_RST;
      readData_reg      <= PSBP_LATCH_RST;
      ibf_reg           <= PSBP_FLAG_RST;
      obf_reg           <= PSBP_FLAG_RST;
      input_overflow_flag_reg          <= PSBP_FLAG_RST;
      ovfReadSeen_reg   <= PSBP_FLAG_RST;
      irq_reg           <= PSBP_FLAG_RST;
    end
    else if (clkEn)
    begin
      inLatch_reg       <= inLatch_next;
      outLatch_reg      <= outLatch_next;
      lastWriteData_reg <= lastWriteData_next;
      readData_reg      <= readData_next;
      ibf_reg           <= ibf_next;
      obf_reg           <= obf_next;
      input_overflow_flag_reg          <= input_overflow_flag_next;
      ovfReadSeen_reg   <= ovfReadSeen_next;
      irq_reg           <= irq_next;
    end
  end

  // pin drivers: slave mode ignores the direction bits
  genvar gBit;
  generate
    for (gBit = 0; gBit < PSBP_DATA_W; gBit++)
    begin : gPin
      always_comb
      begin
        if (slaveModeEnable)
          dataPinOeN[gBit] = !readActive;
        else
          dataPinOeN[gBit] = dataPinDirection[gBit];
      end
    end
  endgenerate

  assign dataPinOut        = outLatch_reg;
  assign fwReadData        = readData_reg;
  assign inputFullFlag     = ibf_reg;
  assign outputFullFlag    = obf_reg;
  assign inputOverflowFlag = input_overflow_flag_reg;
  assign portIrqFlag       = irq_reg;
  assign portIrqRequest    = irq_reg && portIrqEnable;

endmodule

`default_nettype wire

// ===== tb/psbp_master.sv
// external byte bus master facing the slave port pins
// assumes sys_clk shared with the device; pins move 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module psbp_master (
  // clock
  input  wire logic       sys_clk,
  // data pins
  input  wire logic [7:0] dataPinOut,
  input  wire logic [7:0] dataPinOeN,
  output logic      [7:0] dataPinIn,
  // control pins
  output logic            readStrobeN,
  output logic            writeStrobeN,
  output logic            chipSelectN
);
  logic [7:0] drv = 8'h00;
  logic [7:0] noise = 8'h00;
  logic       busOn = 1'b0;

  initial
  begin
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    chipSelectN = 1'b1;
  end

  // a released bus never shows a stale copy of the last byte
  always @(posedge sys_clk)
    noise <= {noise[6:0], ~noise[7]};
  always_comb
    for (int i = 0; i < 8; i++)
      dataPinIn[i] = !dataPinOeN[i] ? dataPinOut[i] : busOn ? drv[i] : noise[i];

  // one byte per strobe; data held 3 edges past the rise for the synchroniser
  task automatic xfer(input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #1;
    chipSelectN = 1'b0;
    readStrobeN = !rd;
    writeStrobeN = rd;
    drv = d;
    busOn = !rd;
    repeat (5) @(posedge sys_clk);
    q = dataPinIn;
    #1;
    chipSelectN = 1'b1;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    busOn = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== tb/psbp_props.sv
// assertion checker for psbp_port, bound to its ports
// assumes one clock, sync active-low reset; clkEn low freezes the phase mirror
`timescale 1ns/1ps
`default_nettype none
module psbp_props
  import psbp_pkg::*;
(
  // clock, reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       clkEn,
  // firmware side
  input wire logic       slaveModeEnable,
  input wire logic       fwDataRead,
  input wire logic       fwOverflowClear,
  input wire logic       fwIrqClear,
  // status
  input wire logic       inputFullFlag,
  input wire logic       outputFullFlag,
  input wire logic       inputOverflowFlag,
  input wire logic       portIrqFlag,
  // pins
  input wire logic       readStrobeN,
  input wire logic       writeStrobeN,
  input wire logic       chipSelectN,
  input wire logic [7:0] dataPinOeN
);
  logic       rdNow;
  logic       wrNow;
  logic [1:0] phase_reg, phase_next;
  logic [2:0] rdLen_reg, rdLen_next, idle_reg, idle_next, wrLen_reg, wrLen_next;

  // run lengths saturate at 7 so long strobes never wrap
  always_comb
  begin
    rdNow = slaveModeEnable && !chipSelectN && !readStrobeN;
    wrNow = slaveModeEnable && !chipSelectN && !writeStrobeN;
    phase_next = !rstn ? PSBP_PHASE_RST : clkEn ? phase_reg + PSBP_PHASE_STEP : phase_reg;
    rdLen_next = (!rstn || !rdNow) ? 3'h0 : rdLen_reg + {2'h0, ~&rdLen_reg};
    idle_next = (!rstn || rdNow) ? 3'h0 : idle_reg + {2'h0, ~&idle_reg};
    wrLen_next = (!rstn || !wrNow) ? 3'h0 : wrLen_reg + {2'h0, ~&wrLen_reg};
  end

  always_ff @(posedge sys_clk)
  begin
    phase_reg <= phase_next;
    rdLen_reg <= rdLen_next;
    idle_reg <= idle_next;
    wrLen_reg <= wrLen_next;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  read_drive_a: assert property (rdNow && rdLen_reg >= 3'h2 |-> dataPinOeN == 8'h00)
    else $error("pins not driven during read");
  read_release_a: assert property (slaveModeEnable && !rdNow && idle_reg >= 3'h2 |-> dataPinOeN == 8'hff)
    else $error("pins driven outside read");
  obf_cleared_a: assert property (rdNow && rdLen_reg >= 3'h3 |-> !outputFullFlag)
    else $error("output full during read");
  flags_off_a: assert property (!slaveModeEnable |=> !inputFullFlag && !outputFullFlag)
    else $error("full flags set outside slave mode");
  write_done_a: assert property (slaveModeEnable && !wrNow && wrLen_reg >= 3'h3 |-> ##[1:14] inputFullFlag && portIrqFlag)
    else $error("write end not reported");
  phase_four_a: assert property ($rose(portIrqFlag) || $rose(inputFullFlag) |-> $past(phase_reg) == PSBP_PHASE_FOUR)
    else $error("flag set off phase four");
  read_clears_a: assert property (fwDataRead && phase_reg != PSBP_PHASE_FOUR |=> !inputFullFlag)
    else $error("input full kept after read");
  ovf_set_a: assert property ($rose(inputOverflowFlag) |-> $past(inputFullFlag))
    else $error("overflow without full");
  ovf_hold_a: assert property ($fell(inputOverflowFlag) |-> $past(fwOverflowClear))
    else $error("overflow cleared by itself");
  irq_hold_a: assert property ($fell(portIrqFlag) |-> $past(fwIrqClear))
    else $error("irq flag cleared by itself");

  cover property ($rose(inputOverflowFlag));
  cover property (rdNow && rdLen_reg == 3'h4);
  cover property ($rose(portIrqFlag));
endmodule

bind psbp_port psbp_props i_psbp_props (.*);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for psbp_port with a reference model
// assumes psbp_master on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psbp_pkg::*;
  logic       sys_clk, rstn, clkEn, slaveModeEnable, portIrqEnable, portIrqRequest;
  logic       fwDataWrite, fwDataRead, fwOverflowClear, fwIrqClear;
  logic       inputFullFlag, outputFullFlag, inputOverflowFlag, portIrqFlag;
  logic       readStrobeN, writeStrobeN, chipSelectN;
  logic [7:0] dataPinDirection, fwWriteData, fwReadData, dataPinIn, dataPinOut, dataPinOeN, q, mIn, mOut;
  logic [31:0] x, r;
  int         n_fail, comparisons;
  bit         mIbf, mObf, mOvf, armed, rdBusy;

  psbp_port i_psbp_port (
    .sys_clk           (sys_clk),
    .rstn              (rstn),
    .clkEn             (clkEn),
    .slaveModeEnable   (slaveModeEnable),
    .dataPinDirection  (dataPinDirection),
    .portIrqEnable     (portIrqEnable),
    .fwDataWrite       (fwDataWrite),
    .fwWriteData       (fwWriteData),
    .fwDataRead        (fwDataRead),
    .fwReadData        (fwReadData),
    .fwOverflowClear   (fwOverflowClear),
    .fwIrqClear        (fwIrqClear),
    .inputFullFlag     (inputFullFlag),
    .outputFullFlag    (outputFullFlag),
    .inputOverflowFlag (inputOverflowFlag),
    .portIrqFlag       (portIrqFlag),
    .portIrqRequest    (portIrqRequest),
    .readStrobeN       (readStrobeN),
    .writeStrobeN      (writeStrobeN),
    .chipSelectN       (chipSelectN),
    .dataPinIn         (dataPinIn),
    .dataPinOut        (dataPinOut),
    .dataPinOeN        (dataPinOeN)
  );
  psbp_master i_psbp_master (
    .sys_clk      (sys_clk),
    .dataPinOut   (dataPinOut),
    .dataPinOeN   (dataPinOeN),
    .dataPinIn    (dataPinIn),
    .readStrobeN  (readStrobeN),
    .writeStrobeN (writeStrobeN),
    .chipSelectN  (chipSelectN)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s: expected %h, seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic flags();
    chk("inputFull", inputFullFlag, mIbf);
    chk("outputFull", outputFullFlag, mObf);
    chk("overflow", inputOverflowFlag, mOvf);
  endtask

  // m: bit0 write, bit1 read, bit2 overflow clear, bit3 irq clear
  task automatic pulse(input logic [3:0] m, input logic [7:0] d);
    {fwIrqClear, fwOverflowClear, fwDataRead, fwDataWrite} = m;
    fwWriteData = d;
    tick();
    {fwIrqClear, fwOverflowClear, fwDataRead, fwDataWrite} = 4'h0;
    if (m[0])
    begin
      mOut = d;
      mObf = slaveModeEnable && !rdBusy;
    end
    if (m[1])
    begin
      mIbf = 1'b0;
      armed |= mOvf;
      chk("fwRead", fwReadData, mIn);
    end
    if (m[2] && armed)
    begin
      mOvf = 1'b0;
      armed = 1'b0;
    end
    if (m[3])
      chk("irqFlag", portIrqFlag, 1'b0);
    flags();
    chk("pins", dataPinOut, mOut);
    tick();
  endtask

  task automatic ext(input logic rd, input logic [7:0] d);
    int k;
    i_psbp_master.xfer(rd, d, q);
    k = 0;
    while (portIrqFlag !== 1'b1 && k < 30)
    begin
      tick();
      k++;
    end
    if (portIrqFlag !== 1'b1)
    begin
      n_fail++;
      complete_run();
    end
    if (rd)
    begin
      mObf = 1'b0;
      chk("extRead", q, mOut);
    end
    else
    begin
      if (mIbf)
      begin
        mOvf = 1'b1;
        armed = 1'b0;
      end
      mIbf = 1'b1;
      mIn = d;
    end
    flags();
    chk("irqReq", portIrqRequest, portIrqEnable);
    pulse(4'h8, 8'h00);
  endtask

  initial
  begin
    x = 32'hc568_631e;
    rstn = 1'b0;
    clkEn = 1'b1;
    slaveModeEnable = 1'b0;
    portIrqEnable = 1'b1;
    dataPinDirection = 8'hff;
    fwWriteData = 8'h00;
    {fwIrqClear, fwOverflowClear, fwDataRead, fwDataWrite} = 4'h0;
    mIn = 8'h00;
    mOut = 8'h00;
    tick(10);
    rstn = 1'b1;
    flags();
    chk("pins", dataPinOut, 8'h00);
    r = rnd();
    dataPinDirection = r[7:0];
    tick();
    chk("oeN", dataPinOeN, r[7:0]);
    i_psbp_master.xfer(1'b0, r[15:8], q);
    pulse(4'h1, r[23:16]);
    slaveModeEnable = 1'b1;
    tick(3);
    chk("oeN", dataPinOeN, 8'hff);
    pulse(4'h1, r[31:24]);
    ext(1'b1, 8'h00);
    ext(1'b0, 8'(rnd()));
    pulse(4'h2, 8'h00);
    for (int i = 0; i < 2; i++)
      ext(1'b0, 8'(rnd()));
    pulse(4'h4, 8'h00);
    pulse(4'h2, 8'h00);
    pulse(4'h4, 8'h00);
    pulse(4'h1, 8'h3c);
    rdBusy = 1'b1;
    fork
      ext(1'b1, 8'h00);
      begin
        tick(4);
        pulse(4'h1, 8'hc3);
      end
    join
    rdBusy = 1'b0;
    // firmware read mid-write sees the live pins and empties input full
    fork
      ext(1'b0, 8'h96);
      begin
        tick(4);
        fwDataRead = 1'b1;
        tick();
        fwDataRead = 1'b0;
        mIbf = 1'b0;
        armed |= mOvf;
        chk("liveRead", fwReadData, 8'h96);
      end
    join
    // mixed traffic, irq enable toggled to check masking
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      portIrqEnable = r[8];
      case (r[1:0])
        2'h0: ext(1'b0, r[15:8]);
        2'h1: ext(1'b1, 8'h00);
        2'h2: pulse(4'h1, r[23:16]);
        default: pulse({1'b0, r[2], 2'h2}, 8'h00);
      endcase
    end
    // clock enable low: a firmware write must not land
    clkEn = 1'b0;
    fwDataWrite = 1'b1;
    fwWriteData = ~mOut;
    tick();
    {clkEn, fwDataWrite} = 2'b10;
    chk("frozenPins", dataPinOut, mOut);
    flags();
    tick();
    for (int i = 0; i < 2; i++)
      ext(1'b0, 8'(rnd()));
    slaveModeEnable = 1'b0;
    tick();
    mIbf = 1'b0;
    mObf = 1'b0;
    flags();
    complete_run();
  end
endmodule
`default_nettype wire
